// ---- inc/qupc_pkg.sv ----
`default_nettype none
package qupc_pkg;

    // ****************************************************************
    // Clocking and serial timing
    // ****************************************************************
    localparam int         CLK_HZ      = 20_000_000;
    localparam int         BAUD_HZ     = 125_000;
    localparam int         OVS         = 16;
    localparam int         TICK_CYC    = CLK_HZ / (OVS * BAUD_HZ);
    localparam logic [3:0] TICK_LAST   = 4'(TICK_CYC - 1);
    localparam logic [3:0] TK_HALF     = 4'h7;
    localparam logic [3:0] TK_LAST     = 4'hF;
    localparam logic [2:0] RX_BIT_LAST = 3'h7;
    localparam logic [3:0] TX_BIT_LAST = 4'h9;
    // Receive timeout is four character times of ten bits each.
    localparam logic [9:0] TIMEOUT_TK  = 10'(4 * 10 * OVS);

    // ****************************************************************
    // Sizes and thresholds
    // ****************************************************************
    localparam int         NCH            = 4;
    localparam logic [4:0] FIFO_DEPTH     = 5'h10;
    localparam logic [4:0] HOLD_DEPTH     = 5'h01;
    localparam logic [4:0] AUTO_RTS_LEVEL = 5'h0E;

    // ****************************************************************
    // Register offsets and bit positions
    // ****************************************************************
    localparam logic [2:0] OFS_DATA       = 3'h0;
    localparam logic [2:0] OFS_IMASK      = 3'h1;
    localparam logic [2:0] OFS_ISTAT      = 3'h2;
    localparam logic [2:0] OFS_FIFO_CTRL  = 3'h3;
    localparam logic [2:0] OFS_MODEM_CTRL = 3'h4;
    localparam logic [2:0] OFS_LINE_STAT  = 3'h5;
    localparam logic [2:0] OFS_MODEM_STAT = 3'h6;
    localparam int MC_TERM_READY  = 0;
    localparam int MC_RTS         = 1;
    localparam int MC_INT_GATE    = 3;
    localparam int MC_LOOP        = 4;
    localparam int IRQ_RX_DATA    = 0;
    localparam int IRQ_TX_EMPTY   = 1;
    localparam int IRQ_RX_ERR     = 2;
    localparam int IRQ_MODEM      = 3;
    localparam int FCR_ENABLE     = 0;
    localparam int FCR_AUTO_RTS   = 1;

    // ****************************************************************
    // Types
    // ****************************************************************
    typedef enum logic [3:0] {
        RX_IDLE = 4'h1, RX_START = 4'h2, RX_DATA = 4'h4, RX_STOP = 4'h8
    } qupc_rx_state_t;
    typedef enum logic [1:0] {TX_IDLE = 2'h1, TX_BUSY = 2'h2} qupc_tx_state_t;

    typedef struct packed {
        logic dcd_n;
        logic ring_indicate_in_n;
        logic dsr_n;
        logic cts_n;
    } qupc_modem_in_t;

    typedef struct packed {
        logic [4:0]     mctl;
        logic [3:0]     imask;
        logic [3:0]     istat;
        logic [1:0]     fcr;
        logic           overrun;
        logic           frame_err;
        logic [1:0]     rx_sync;
        logic [3:0]     mdm_s1;
        logic [3:0]     mdm_s2;
        logic [3:0]     mdm_prev;
        qupc_rx_state_t rx_st;
        logic [3:0]     rx_tk;
        logic [2:0]     rx_bit;
        logic [7:0]     rx_sh;
        qupc_tx_state_t tx_st;
        logic [3:0]     tx_tk;
        logic [3:0]     tx_bit;
        logic [9:0]     tx_sh;
        logic           txd;
        logic [9:0]     idle_tk;
        logic [4:0]     rx_wp;
        logic [4:0]     rx_rp;
        logic [4:0]     tx_wp;
        logic [4:0]     tx_rp;
        logic           ser_out;
        logic           term_n;
        logic           rts_n;
        logic           irq;
        logic           irq_oe_n;
        logic           rx_rdy;
        logic           tx_rdy;
    } qupc_chan_t;

    localparam qupc_chan_t CHAN_RST = '{
        mctl: 5'h00, imask: 4'h0, istat: 4'h0, fcr: 2'h0, overrun: 1'b0,
        frame_err: 1'b0, rx_sync: 2'h3, mdm_s1: 4'hF, mdm_s2: 4'hF,
        mdm_prev: 4'hF, rx_st: RX_IDLE, rx_tk: 4'h0, rx_bit: 3'h0,
        rx_sh: 8'h00, tx_st: TX_IDLE, tx_tk: 4'h0, tx_bit: 4'h0,
        tx_sh: 10'h3FF, txd: 1'b1, idle_tk: 10'h000, rx_wp: 5'h00,
        rx_rp: 5'h00, tx_wp: 5'h00, tx_rp: 5'h00, ser_out: 1'b1,
        term_n: 1'b1, rts_n: 1'b1, irq: 1'b0, irq_oe_n: 1'b1,
        rx_rdy: 1'b1, tx_rdy: 1'b1};

    typedef struct packed {
        qupc_chan_t [NCH-1:0] ch;
        logic [3:0]           tick_cnt;
        logic                 tick;
        logic [1:0]           mode_sync;
        logic [7:0]           rdata;
    } qupc_state_t;

    localparam qupc_state_t STATE_RST = '{ch: {NCH{CHAN_RST}}, tick_cnt: 4'h0,
        tick: 1'b0, mode_sync: 2'h0, rdata: 8'h00};

endpackage : qupc_pkg
`default_nettype wire

// ---- logic/qupc_fifo_ram.sv ----
`timescale 1ns/1ns
`default_nettype none
module qupc_fifo_ram (
    input  wire logic       sys_clk,
    input  wire logic       wr_en,
    input  wire logic [3:0] wr_addr,
    input  wire logic [7:0] wr_data,
    input  wire logic [3:0] rd_addr,
    output logic      [7:0] rd_data
);
    // ****************************************************************
    // Storage with registered read and write-through
    // ****************************************************************
    typedef struct packed {
        logic [15:0][7:0] mem;
        logic [7:0]       rd;
    } qupc_ram_t;

    qupc_ram_t r_q;
    qupc_ram_t r_d;

    // A word written to the address being read shows up at once, so a
    // FIFO that was empty presents its new head one cycle after the push.
    always_comb begin
        r_d = r_q;
        if (wr_en) begin
            r_d.mem[wr_addr] = wr_data;
        end
        r_d.rd = r_d.mem[rd_addr];
    end

    always_ff @(posedge sys_clk) begin
        r_q <= r_d;
    end

    assign rd_data = r_q.rd;

endmodule : qupc_fifo_ram
`default_nettype wire

// ---- logic/qupc_top.sv ----
// Implementation choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module qupc_top (
    input  wire logic                          sys_clk,
    input  wire logic                          srst,
    input  wire logic [2:0]                    register_address_input,
    input  wire logic [3:0]                    channel_select,
    input  wire logic                          write_strobe,
    input  wire logic                          read_strobe,
    input  wire logic [7:0]                    write_data,
    output logic      [7:0]                    read_data,
    input  wire logic                          interrupt_mode_select,
    input  wire logic [3:0]                    serial_in,
    input  wire qupc_pkg::qupc_modem_in_t [3:0] modem_in,
    output logic      [3:0]                    serial_out,
    output logic      [3:0]                    terminal_ready_out_n,
    output logic      [3:0]                    request_to_send_out_n,
    output logic      [3:0]                    channel_interrupt_out,
    output logic      [3:0]                    channel_interrupt_oe_n,
    output logic      [3:0]                    receive_dma_ready,
    output logic      [3:0]                    transmit_dma_ready
);
    import qupc_pkg::*;

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Fill level of a FIFO whose pointers carry one wrap bit.
    function automatic logic [4:0] fifo_cnt(input logic [4:0] wp, input logic [4:0] rp);
        fifo_cnt = wp - rp;
    endfunction : fifo_cnt

    // With FIFO mode off each direction behaves as a one-word holding register.
    function automatic logic fifo_full(input logic [4:0] wp, input logic [4:0] rp,
                                       input logic en);
        fifo_full = fifo_cnt(wp, rp) >= (en ? FIFO_DEPTH : HOLD_DEPTH);
    endfunction : fifo_full

    // ****************************************************************
    // State and FIFO storage wiring
    // ****************************************************************
    qupc_state_t s_q;
    qupc_state_t s_d;

    logic [NCH-1:0]      rx_we;
    logic [NCH-1:0][3:0] rx_wa;
    logic [NCH-1:0][7:0] rx_wd;
    logic [NCH-1:0][3:0] rx_ra;
    logic [NCH-1:0][7:0] rx_q;
    logic [NCH-1:0]      tx_we;
    logic [NCH-1:0][3:0] tx_wa;
    logic [NCH-1:0][3:0] tx_ra;
    logic [NCH-1:0][7:0] tx_q;

    // One receive and one transmit store per channel.
    for (genvar g = 0; g < NCH; g++) begin : g_ch
        qupc_fifo_ram u_rx_ram (
            .sys_clk (sys_clk),
            .wr_en   (rx_we[g]),
            .wr_addr (rx_wa[g]),
            .wr_data (rx_wd[g]),
            .rd_addr (rx_ra[g]),
            .rd_data (rx_q[g])
        );
        qupc_fifo_ram u_tx_ram (
            .sys_clk (sys_clk),
            .wr_en   (tx_we[g]),
            .wr_addr (tx_wa[g]),
            .wr_data (write_data),
            .rd_addr (tx_ra[g]),
            .rd_data (tx_q[g])
        );
    end

    // ****************************************************************
    // Next-state logic
    // ****************************************************************

    // All four channels run the same logic on their own slice of the state.
    always_comb begin
        qupc_chan_t c;
        logic       wr;
        logic       rd;
        logic       hit;
        logic       rx_in;
        logic [3:0] ev;
        logic [3:0] clr;
        logic [4:0] rcnt;
        c   = s_q.ch[0];
        wr  = 1'b0;
        rd  = 1'b0;
        hit = 1'b0;
        rx_in = 1'b1;
        ev  = 4'h0;
        clr = 4'h0;
        rcnt = 5'h00;
        rx_we = '0;
        rx_wa = '0;
        rx_wd = '0;
        rx_ra = '0;
        tx_we = '0;
        tx_wa = '0;
        tx_ra = '0;
        s_d = s_q;

        // Shared bit-rate enable: one pulse every TICK_CYC clocks.
        s_d.tick     = (s_q.tick_cnt == TICK_LAST);
        s_d.tick_cnt = s_d.tick ? 4'h0 : s_q.tick_cnt + 4'h1;
        s_d.mode_sync = {s_q.mode_sync[0], interrupt_mode_select};
        s_d.rdata    = 8'h00;

        for (int i = 0; i < NCH; i++) begin
            c   = s_q.ch[i];
            ev  = 4'h0;
            clr = 4'h0;
            wr  = write_strobe && channel_select[i];
            rd  = read_strobe && channel_select[i];

            // Pins from the modem side pass two flops; only the second is compared.
            c.rx_sync  = {s_q.ch[i].rx_sync[0], serial_in[i]};
            c.mdm_s1   = modem_in[i];
            c.mdm_s2   = s_q.ch[i].mdm_s1;
            c.mdm_prev = s_q.ch[i].mdm_s2;
            if (s_q.ch[i].mdm_s2 != s_q.ch[i].mdm_prev) begin
                ev[IRQ_MODEM] = 1'b1;
            end
            rx_in = s_q.ch[i].mctl[MC_LOOP] ? s_q.ch[i].txd : s_q.ch[i].rx_sync[1];

            // Register writes through the shared address inputs.
            if (wr) begin
                case (register_address_input)
                    OFS_DATA: begin
                        if (!fifo_full(s_q.ch[i].tx_wp, s_q.ch[i].tx_rp, c.fcr[FCR_ENABLE])) begin
                            tx_we[i] = 1'b1;
                            tx_wa[i] = c.tx_wp[3:0];
                            c.tx_wp  = c.tx_wp + 5'h01;
                        end
                    end
                    OFS_IMASK:      c.imask = write_data[3:0];
                    OFS_ISTAT:      clr     = write_data[3:0];
                    OFS_FIFO_CTRL:  c.fcr   = write_data[1:0];
                    OFS_MODEM_CTRL: c.mctl  = write_data[4:0];
                    default: ;
                endcase
            end

            // Reads: the lowest selected channel answers, data one cycle later.
            if (rd && !hit) begin
                hit = 1'b1;
                case (register_address_input)
                    OFS_DATA: begin
                        if (c.rx_wp != c.rx_rp) begin
                            s_d.rdata = rx_q[i];
                            c.rx_rp   = c.rx_rp + 5'h01;
                            c.idle_tk = 10'h000;
                        end
                    end
                    OFS_IMASK:      s_d.rdata = {4'h0, c.imask};
                    OFS_ISTAT:      s_d.rdata = {4'h0, c.istat};
                    OFS_FIFO_CTRL:  s_d.rdata = {6'h00, c.fcr};
                    OFS_MODEM_CTRL: s_d.rdata = {3'h0, c.mctl};
                    OFS_LINE_STAT: begin
                        // Reading line status clears the error flags; a new error
                        // in the same cycle is set again below and survives.
                        s_d.rdata = {1'b0,
                                     (c.tx_wp == c.tx_rp) && (c.tx_st == TX_IDLE),
                                     c.tx_wp == c.tx_rp, 1'b0, c.frame_err, 1'b0,
                                     c.overrun, c.rx_wp != c.rx_rp};
                        c.overrun   = 1'b0;
                        c.frame_err = 1'b0;
                    end
                    OFS_MODEM_STAT: s_d.rdata = {~s_q.ch[i].mdm_s2, 4'h0};
                    default:        s_d.rdata = 8'h00;
                endcase
            end

            // Receiver: start check at mid bit, eight data bits, one stop bit.
            if (s_q.tick) begin
                case (c.rx_st)
                    RX_IDLE: begin
                        if (!rx_in) begin
                            c.rx_st = RX_START;
                            c.rx_tk = 4'h0;
                        end
                    end
                    RX_START: begin
                        if (c.rx_tk == TK_HALF) begin
                            c.rx_st  = rx_in ? RX_IDLE : RX_DATA;
                            c.rx_tk  = 4'h0;
                            c.rx_bit = 3'h0;
                        end else begin
                            c.rx_tk = c.rx_tk + 4'h1;
                        end
                    end
                    RX_DATA: begin
                        if (c.rx_tk == TK_LAST) begin
                            c.rx_sh = {rx_in, c.rx_sh[7:1]};
                            if (c.rx_bit == RX_BIT_LAST) begin
                                c.rx_st = RX_STOP;
                            end
                            c.rx_bit = c.rx_bit + 3'h1;
                        end
                        c.rx_tk = c.rx_tk + 4'h1;
                    end
                    RX_STOP: begin
                        if (c.rx_tk == TK_LAST) begin
                            c.rx_st   = RX_IDLE;
                            c.idle_tk = 10'h000;
                            if (!rx_in) begin
                                c.frame_err    = 1'b1;
                                ev[IRQ_RX_ERR] = 1'b1;
                            end
                            if (fifo_full(c.rx_wp, c.rx_rp, c.fcr[FCR_ENABLE])) begin
                                c.overrun      = 1'b1;
                                ev[IRQ_RX_ERR] = 1'b1;
                            end else begin
                                rx_we[i]        = 1'b1;
                                rx_wa[i]        = c.rx_wp[3:0];
                                rx_wd[i]        = c.rx_sh;
                                c.rx_wp         = c.rx_wp + 5'h01;
                                ev[IRQ_RX_DATA] = 1'b1;
                            end
                        end
                        c.rx_tk = c.rx_tk + 4'h1;
                    end
                    default: c.rx_st = RX_IDLE;
                endcase
            end

            // Character timeout only counts in FIFO mode with data left waiting.
            if (s_q.tick && c.fcr[FCR_ENABLE] && (c.rx_st == RX_IDLE) &&
                (c.rx_wp != c.rx_rp) && (c.idle_tk != TIMEOUT_TK)) begin
                c.idle_tk = c.idle_tk + 10'h001;
                if (c.idle_tk == TIMEOUT_TK) begin
                    ev[IRQ_RX_DATA] = 1'b1;
                end
            end

            // Transmitter: the store presents the head word, so a load takes it directly.
            case (c.tx_st)
                TX_IDLE: begin
                    if (s_q.ch[i].tx_wp != s_q.ch[i].tx_rp) begin
                        c.tx_sh  = {1'b1, tx_q[i], 1'b0};
                        c.tx_rp  = c.tx_rp + 5'h01;
                        c.tx_st  = TX_BUSY;
                        c.tx_tk  = 4'h0;
                        c.tx_bit = 4'h0;
                        if (c.tx_rp == c.tx_wp) begin
                            ev[IRQ_TX_EMPTY] = 1'b1;
                        end
                    end
                end
                TX_BUSY: begin
                    if (s_q.tick) begin
                        if (c.tx_tk == TK_LAST) begin
                            c.tx_sh = {1'b1, c.tx_sh[9:1]};
                            if (c.tx_bit == TX_BIT_LAST) begin
                                c.tx_st = TX_IDLE;
                            end
                            c.tx_bit = c.tx_bit + 4'h1;
                        end
                        c.tx_tk = c.tx_tk + 4'h1;
                    end
                end
                default: c.tx_st = TX_IDLE;
            endcase
            c.txd = (c.tx_st == TX_BUSY) ? c.tx_sh[0] : 1'b1;

            // Store read addresses follow the next pointers so heads stay current.
            rx_ra[i] = c.rx_rp[3:0];
            tx_ra[i] = c.tx_rp[3:0];

            // Interrupt status: a hardware set beats a software clear.
            c.istat = (c.istat & ~clr) | ev;
            c.irq   = |(c.istat & c.imask);
            c.irq_oe_n = ~(s_q.mode_sync[1] || c.mctl[MC_INT_GATE]);

            // Pin levels are registered, so they move on the same edge as the state.
            rcnt      = fifo_cnt(c.rx_wp, c.rx_rp);
            c.ser_out = c.mctl[MC_LOOP] ? 1'b1 : c.txd;
            c.term_n  = ~c.mctl[MC_TERM_READY];
            c.rts_n   = ~(c.mctl[MC_RTS] && !c.mctl[MC_LOOP] &&
                          !(c.fcr[FCR_AUTO_RTS] && c.fcr[FCR_ENABLE] &&
                            (rcnt >= AUTO_RTS_LEVEL)));
            c.rx_rdy  = ~fifo_full(c.rx_wp, c.rx_rp, c.fcr[FCR_ENABLE]);
            c.tx_rdy  = ~fifo_full(c.tx_wp, c.tx_rp, c.fcr[FCR_ENABLE]);
            s_d.ch[i] = c;
        end

        // Reset brings every pin to its idle level and drops the interrupt enables.
        if (srst) begin
            s_d   = STATE_RST;
            rx_we = '0;
            tx_we = '0;
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge sys_clk) begin
        s_q <= s_d;
    end

    // ****************************************************************
    // Outputs, each straight from a state flop
    // ****************************************************************
    assign read_data = s_q.rdata;

    // Per-channel pins are pulled out of the state slices.
    always_comb begin
        for (int k = 0; k < NCH; k++) begin
            serial_out[k]             = s_q.ch[k].ser_out;
            terminal_ready_out_n[k]   = s_q.ch[k].term_n;
            request_to_send_out_n[k]  = s_q.ch[k].rts_n;
            channel_interrupt_out[k]  = s_q.ch[k].irq;
            channel_interrupt_oe_n[k] = s_q.ch[k].irq_oe_n;
            receive_dma_ready[k]      = s_q.ch[k].rx_rdy;
            transmit_dma_ready[k]     = s_q.ch[k].tx_rdy;
        end
    end

endmodule : qupc_top
`default_nettype wire

// ---- test/qupc_top_sva.sv ----
`timescale 1ns/1ns
`default_nettype none
// ***
// Pin checks
// ***
module qupc_top_chk
    import qupc_pkg::*;
(
    input wire logic       sys_clk,
    input wire logic       srst,
    input wire logic [2:0] register_address_input,
    input wire logic [3:0] channel_select,
    input wire logic       write_strobe,
    input wire logic [7:0] write_data,
    input wire logic       interrupt_mode_select,
    input wire logic [3:0] serial_out,
    input wire logic [3:0] terminal_ready_out_n,
    input wire logic [3:0] request_to_send_out_n,
    input wire logic [3:0] channel_interrupt_out,
    input wire logic [3:0] channel_interrupt_oe_n
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (srst);
    // Control write to channel 0, the cause that half the pin checks hang on.
    wire mcw0 = write_strobe && channel_select[0] && register_address_input == OFS_MODEM_CTRL;
    rst_pins_a: assert property (disable iff (1'b0) srst |=>
        (serial_out & terminal_ready_out_n & request_to_send_out_n) == 4'hF) else $error("pins not reset");
    irq_reset_a: assert property (disable iff (1'b0) srst |=>
        channel_interrupt_oe_n == 4'hF && channel_interrupt_out == 4'h0) else $error("irq not off");
    term_ready_a: assert property (mcw0 |=>
        terminal_ready_out_n[0] == !$past(write_data[0])) else $error("terminal ready wrong");
    rts_off_a: assert property (mcw0 && !(write_data[1] && !write_data[4]) |=>
        request_to_send_out_n[0]) else $error("rts active");
    irq_gate_a: assert property ((!interrupt_mode_select)[*4] ##0 mcw0 |=>
        channel_interrupt_oe_n[0] == !$past(write_data[3])) else $error("gate ignored");
    irq_all_on_a: assert property (interrupt_mode_select[*4] |->
        channel_interrupt_oe_n == 4'h0) else $error("override ignored");
    sel_gate_a: assert property (write_strobe && !channel_select[1] |=>
        $stable(terminal_ready_out_n[1])) else $error("unselected channel moved");
    loop_mark_a: assert property (mcw0 && write_data[4] |->
        ##2 serial_out[0] [*6]) else $error("loop not marking");
    cover property (mcw0 && write_data[4]);
    cover property (channel_interrupt_out[0] && !channel_interrupt_oe_n[0]);
    cover property (interrupt_mode_select[*4]);
endmodule : qupc_top_chk
`default_nettype wire

// ---- test/qupc_modem_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ***
// Modem at the far end
// ***
module qupc_modem_model
    import qupc_pkg::*;
(
    input  wire logic           sys_clk,
    input  wire logic [3:0]     ring_req,
    input  wire logic [3:0]     serial_out,
    output var logic [3:0]      serial_in,
    output var qupc_modem_in_t [3:0] modem_in
);
    // The modem echoes each line one clock late, so whatever is sent comes back.
    always @(posedge sys_clk) serial_in <= serial_out;
    // Carrier, set ready and clear to send stay active; ring follows the bench.
    always_comb begin
        for (int c = 0; c < 4; c++) begin
            modem_in[c] = '{dcd_n: 1'b0, ring_indicate_in_n: !ring_req[c], dsr_n: 1'b0, cts_n: 1'b0};
        end
    end
endmodule : qupc_modem_model
`default_nettype wire

// ---- test/qupc_top_tb.sv ----
`timescale 1ns/1ns
`default_nettype none
// ***
// Bench
// ***
module qupc_top_tb;
    import qupc_pkg::*;
    logic       sys_clk = 1'b0, srst = 1'b1, write_strobe = 1'b0, read_strobe = 1'b0, rd_pend = 1'b0;
    logic       interrupt_mode_select = 1'b0;
    logic [2:0] register_address_input = 3'h0;
    logic [3:0] channel_select = 4'h0, ring_req = 4'h0;
    logic [7:0] write_data = 8'h00, read_data, d, b0;
    logic [3:0] serial_in, serial_out, terminal_ready_out_n, request_to_send_out_n;
    logic [3:0] channel_interrupt_out, channel_interrupt_oe_n, receive_dma_ready, transmit_dma_ready;
    qupc_modem_in_t [3:0] modem_in;
    logic [15:0] expq[$];
    logic [15:0] note;
    int         n_fail = 0, n_checks = 0, cyc = 0;
    qupc_top DUT (.sys_clk, .srst, .register_address_input, .channel_select, .write_strobe, .read_strobe,
        .write_data, .read_data, .interrupt_mode_select, .serial_in, .modem_in, .serial_out,
        .terminal_ready_out_n, .request_to_send_out_n, .channel_interrupt_out, .channel_interrupt_oe_n,
        .receive_dma_ready, .transmit_dma_ready);
    qupc_modem_model MODEM (.sys_clk, .ring_req, .serial_out, .serial_in, .modem_in);
    // Half of the 50 ns period.
    always #25 sys_clk = ~sys_clk;
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : report_and_stop
    // Write, then two quiet cycles so registered pins have settled.
    task automatic wr(input logic [2:0] ad, input logic [3:0] cs, input logic [7:0] v);
        register_address_input <= ad;
        channel_select <= cs;
        write_data <= v;
        write_strobe <= 1'b1;
        @(posedge sys_clk);
        write_strobe <= 1'b0;
        repeat (2) @(posedge sys_clk);
    endtask : wr
    // Read; the masked expectation is queued before the strobe goes out.
    task automatic rd(input logic [2:0] ad, input logic [3:0] cs, input logic [7:0] m, input logic [7:0] e);
        expq.push_back({m, e});
        register_address_input <= ad;
        channel_select <= cs;
        read_strobe <= 1'b1;
        @(posedge sys_clk);
        read_strobe <= 1'b0;
        @(posedge sys_clk);
    endtask : rd
    // Read data stand one cycle only, so they are taken mid-cycle.
    always @(posedge sys_clk) rd_pend <= read_strobe;
    always @(negedge sys_clk) begin
        if (rd_pend) begin
            note = expq.pop_front();
            check("read_data", read_data & note[15:8], note[7:0]);
        end
    end
    // Watchdog, about twice the expected run.
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            report_and_stop();
        end
    end
    // Main sequence.
    initial begin
        void'($urandom(24801));
        repeat (12) @(posedge sys_clk);
        check("reset pins", {serial_out, terminal_ready_out_n}, 8'hFF);
        check("reset irq", {channel_interrupt_oe_n, channel_interrupt_out}, 8'hF0);
        srst <= 1'b0;
        repeat (2) @(posedge sys_clk);
        $display("reset test done");
        for (int i = 0; i < 8; i++) begin
            d = 8'($urandom) & 8'h1B;
            wr(OFS_MODEM_CTRL, 4'(1 << (i % 4)), d);
            check("pins", 8'({terminal_ready_out_n[i % 4], request_to_send_out_n[i % 4],
                channel_interrupt_oe_n[i % 4]}), 8'({!d[0], !(d[1] && !d[4]), !d[3]}));
            wr(OFS_MODEM_CTRL, 4'h0, ~d);
            rd(OFS_MODEM_CTRL, 4'(1 << (i % 4)), 8'h1F, d);
        end
        $display("control test done");
        wr(OFS_MODEM_CTRL, 4'h1, 8'h08);
        wr(OFS_IMASK, 4'h1, 8'h08);
        check("irq on", 8'({channel_interrupt_out[0], channel_interrupt_oe_n[0]}), 8'h02);
        ring_req <= 4'h1;
        repeat (6) @(posedge sys_clk);
        rd(OFS_MODEM_STAT, 4'h1, 8'hF0, 8'hF0);
        rd(OFS_MODEM_STAT, 4'h2, 8'hF0, 8'hB0);
        wr(OFS_IMASK, 4'h1, 8'h00);
        check("irq masked", 8'(channel_interrupt_out[0]), 8'h00);
        wr(OFS_ISTAT, 4'h1, 8'h08);
        wr(OFS_IMASK, 4'h1, 8'h08);
        check("irq cleared", 8'(channel_interrupt_out[0]), 8'h00);
        wr(OFS_MODEM_CTRL, 4'hF, 8'h00);
        interrupt_mode_select <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check("override", 8'(channel_interrupt_oe_n), 8'h00);
        interrupt_mode_select <= 1'b0;
        repeat (4) @(posedge sys_clk);
        check("gated", 8'(channel_interrupt_oe_n), 8'h0F);
        $display("interrupt test done");
        d = 8'($urandom);
        wr(OFS_MODEM_CTRL, 4'h2, 8'h12);
        wr(OFS_DATA, 4'h2, d);
        repeat (1800) @(posedge sys_clk);
        check("loop pins", 8'({serial_out[1], request_to_send_out_n[1]}), 8'h03);
        rd(OFS_DATA, 4'h2, 8'hFF, d);
        $display("loop test done");
        wr(OFS_FIFO_CTRL, 4'h4, 8'h03);
        wr(OFS_MODEM_CTRL, 4'h4, 8'h02);
        check("rts on", 8'(request_to_send_out_n[2]), 8'h00);
        b0 = 8'($urandom);
        wr(OFS_DATA, 4'h4, b0);
        repeat (16) wr(OFS_DATA, 4'h4, 8'($urandom));
        check("tx full", 8'(transmit_dma_ready[2]), 8'h00);
        repeat (28000) @(posedge sys_clk);
        check("rx full", 8'({receive_dma_ready[2], transmit_dma_ready[2], request_to_send_out_n[2]}),
            8'h03);
        rd(OFS_DATA, 4'h4, 8'hFF, b0);
        repeat (2) @(posedge sys_clk);
        check("rx room", 8'(receive_dma_ready[2]), 8'h01);
        $display("fifo test done");
        report_and_stop();
    end
endmodule : qupc_top_tb
bind qupc_top qupc_top_chk CHK (.sys_clk, .srst, .register_address_input, .channel_select, .write_strobe,
    .write_data, .interrupt_mode_select, .serial_out, .terminal_ready_out_n, .request_to_send_out_n,
    .channel_interrupt_out, .channel_interrupt_oe_n);
`default_nettype wire
